// ### hw/auto_low_limit_adjust_params.svh
// Register offsets, field positions, reset values and timing counts
`ifndef AUTO_LOW_LIMIT_ADJUST_PARAMS_SVH
`define AUTO_LOW_LIMIT_ADJUST_PARAMS_SVH

// Word indices (printed offsets are indices; byte address is four times)
`define ZONE1_TOP_TEMP_IDX        8'hae
`define ZONE3_TOP_TEMP_IDX        8'haf
`define ZONE2_TOP_TEMP_IDX        8'hb3
`define REMOTE_STEP_IDX           8'hb4
`define AMBIENT_STEP_DELAY_IDX    8'hb5
`define REMOTE_DELAY_IDX          8'hb6
`define ADJUST_ENABLE_IDX         8'hb7
`define TOP_STATUS_IDX            8'hb8
`define RESERVED_CONFIG_A_IDX     8'hba
`define RESERVED_READONLY_B_IDX   8'hbb
`define LOW_LIMIT_Z1_IDX          8'hc0
`define LOW_LIMIT_Z2_IDX          8'hc1
`define LOW_LIMIT_Z3_IDX          8'hc2
`define CONTROL_IDX               8'hc3
`define IRQ_MASK_IDX              8'hc4

// Reset values
`define TOP_TEMP_RESET            8'h2d
`define ADJ_REG_RESET             8'h00
`define STATUS_RESET              8'h00
`define RESERVED_A_RESET          8'h03
`define RESERVED_B_RESET          8'h00
`define LOW_LIMIT_RESET           8'h00

// Field positions
`define Z1_FIELD_LSB              6
`define Z3_FIELD_LSB              4
`define Z2_STEP_LSB               4
`define Z2_DELAY_LSB              0
`define EN_Z3_BIT                 3
`define EN_Z1_BIT                 2
`define EN_Z2_BIT                 1
`define TOP_INT_EN_BIT            0
`define ST_Z3_BIT                 2
`define ST_Z1_BIT                 1
`define ST_Z2_BIT                 0
`define ADJ_ENABLE_MASK           8'h0f
`define STATUS_MASK               8'h07
`define STEP_FIELD_MASK           8'hf0
`define AMB_FIELD_MASK            8'h33

// Timing
// 64-bit so that one minute of cycles does not overflow
`define CLK_FREQ_HZ               64'h0000_0000_0773_5940
`define MINUTE_S                  64'h0000_0000_0000_003c
`define MINUTE_CYCLES             (`CLK_FREQ_HZ * `MINUTE_S)
`define LOW_TEMP_FLOOR            8'h80

`endif

// ### hw/auto_low_limit_adjust_pkg.sv
// Types shared by the automatic low-limit adjust block
package auto_low_limit_adjust_pkg;

  typedef logic [7:0] temp_t;

  // One zone's working configuration
  typedef struct packed {
    logic       adjust_on;
    logic [1:0] step_code;
    logic [1:0] delay_code;
    temp_t      top_temp;
  } zone_cfg_s;

  // Per-zone adjust sequencer
  typedef enum logic [2:0] {
    ST_WATCH = 3'b001,
    ST_APPLY = 3'b010,
    ST_HOLD  = 3'b100
  } adj_state_e;

endpackage : auto_low_limit_adjust_pkg

// ### hw/zone_adjuster.sv
// One zone's compare, step and hold-off sequencer
`timescale 1ns/100ps
`default_nettype none
`include "auto_low_limit_adjust_params.svh"

module zone_adjuster #(
  parameter longint unsigned MINUTE_CYCLES = `MINUTE_CYCLES
) (
  input  wire logic                                 clk,
  input  wire logic                                 rst_n,
  input  wire logic                                 pg_rise,
  input  wire auto_low_limit_adjust_pkg::zone_cfg_s cfg,
  input  wire auto_low_limit_adjust_pkg::temp_t     reading,
  input  wire logic                                 sw_wr,
  input  wire auto_low_limit_adjust_pkg::temp_t     sw_data,
  output logic                                      exceeded,
  output auto_low_limit_adjust_pkg::temp_t          low_limit
);

  auto_low_limit_adjust_pkg::adj_state_e state_reg;
  logic [32:0] minute_cnt_reg; // A full minute at 125 MHz needs 33 bits
  logic [2:0]  minutes_reg;

  // Step decode: 2, 4, 6 or 8 degrees
  function automatic logic [7:0] step_deg(input logic [1:0] code);
    step_deg = {5'b0_0000, code, 1'b0} + 8'h02;
  endfunction : step_deg

  // Signed floor clamped subtraction
  function automatic logic [7:0] clamp_sub(input logic [7:0] v, input logic [7:0] d);
    logic signed [8:0] r;
    r = $signed({v[7], v}) - $signed({1'b0, d});
    if (r < $signed({1'b1, `LOW_TEMP_FLOOR})) begin
      clamp_sub = `LOW_TEMP_FLOOR;
    end else begin
      clamp_sub = r[7:0];
    end
  endfunction : clamp_sub

  // Exceed compare on signed readings
  assign exceeded = ($signed(reading) > $signed(cfg.top_temp));

  // Sequencer
  always_ff @(posedge clk) begin
    if (!rst_n || pg_rise || !cfg.adjust_on) begin
      state_reg <= auto_low_limit_adjust_pkg::ST_WATCH;
    end else begin
      unique case (state_reg)
        auto_low_limit_adjust_pkg::ST_WATCH: begin
          if (exceeded) state_reg <= auto_low_limit_adjust_pkg::ST_APPLY;
        end
        auto_low_limit_adjust_pkg::ST_APPLY: begin
          state_reg <= auto_low_limit_adjust_pkg::ST_HOLD;
        end
        auto_low_limit_adjust_pkg::ST_HOLD: begin
          if (minutes_reg > {1'b0, cfg.delay_code}) begin
            state_reg <= auto_low_limit_adjust_pkg::ST_WATCH;
          end
        end
        default: state_reg <= auto_low_limit_adjust_pkg::ST_WATCH;
      endcase
    end
  end

  // Minute timer for hold-off
  always_ff @(posedge clk) begin
    if (!rst_n || state_reg != auto_low_limit_adjust_pkg::ST_HOLD) begin
      minute_cnt_reg <= 33'h0_0000_0000;
      minutes_reg    <= 3'h0;
    end else if (minute_cnt_reg == 33'(MINUTE_CYCLES - 1)) begin
      minute_cnt_reg <= 33'h0_0000_0000;
      minutes_reg    <= minutes_reg + 3'h1;
    end else begin
      minute_cnt_reg <= minute_cnt_reg + 33'h0_0000_0001;
    end
  end

  // Low limit: software write or automatic step
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      low_limit <= `LOW_LIMIT_RESET;
    end else if (state_reg == auto_low_limit_adjust_pkg::ST_APPLY) begin
      low_limit <= clamp_sub(low_limit, step_deg(cfg.step_code));
    end else if (sw_wr) begin
      low_limit <= sw_data;
    end
  end

endmodule : zone_adjuster
`default_nettype wire

// ### hw/auto_low_limit_adjust.sv
// Automatic low-limit adjust block with APB register slave
`timescale 1ns/100ps
`default_nettype none
`include "auto_low_limit_adjust_params.svh"

module auto_low_limit_adjust #(
  parameter longint unsigned MINUTE_CYCLES = `MINUTE_CYCLES
) (
  input  wire logic                             clk,
  input  wire logic                             rst_n,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [11:0]                      paddr,
  input  wire logic [31:0]                      pwdata,
  output logic      [31:0]                      prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  input  wire auto_low_limit_adjust_pkg::temp_t zone1_reading,
  input  wire auto_low_limit_adjust_pkg::temp_t zone2_reading,
  input  wire auto_low_limit_adjust_pkg::temp_t zone3_reading,
  input  wire logic                             main_power_good,
  input  wire logic                             config_lock,
  input  wire logic                             global_int_en,
  output logic                                  top_irq,
  output logic                                  monitor_irq_pin_n
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] top1_reg, top2_reg, top3_reg;
  logic [7:0] step_reg, amb_reg, delay_reg, enable_reg, status_reg;
  logic [7:0] rsvd_a_reg, mask_reg, event_reg;
  logic [2:0] pg_sync_reg;
  logic       pg_rise;
  logic [2:0] exceeded;
  logic [7:0] low1, low2, low3;
  logic [2:0] exc_status;
  logic       wr_en, rd_en, hit;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic [7:0] rdata;

  // ----------------------------------------------------------------
  // Power-good rise detect (three-stage sync)
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pg_sync_reg <= 3'b111; // No false rise when the pin is already high
    end else begin
      pg_sync_reg <= {pg_sync_reg[1:0], main_power_good};
    end
  end
  assign pg_rise = pg_sync_reg[1] & ~pg_sync_reg[2];

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign pready  = 1'b1;
  assign idx     = paddr[9:2];
  assign wbyte   = pwdata[7:0];
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;

  // Address match against map
  always_comb begin
    unique case (idx)
      `ZONE1_TOP_TEMP_IDX, `ZONE3_TOP_TEMP_IDX, `ZONE2_TOP_TEMP_IDX,
      `REMOTE_STEP_IDX, `AMBIENT_STEP_DELAY_IDX, `REMOTE_DELAY_IDX,
      `ADJUST_ENABLE_IDX, `TOP_STATUS_IDX, `RESERVED_CONFIG_A_IDX,
      `RESERVED_READONLY_B_IDX, `LOW_LIMIT_Z1_IDX, `LOW_LIMIT_Z2_IDX,
      `LOW_LIMIT_Z3_IDX, `CONTROL_IDX, `IRQ_MASK_IDX: begin
        hit = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
      end
      default: hit = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~hit;

  function automatic logic wr_at(input logic [7:0] i);
    wr_at = wr_en & hit & (idx == i);
  endfunction : wr_at

  // ----------------------------------------------------------------
  // Configuration registers, frozen by lock except the reserved register and interrupt mask
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n || pg_rise) begin
      top1_reg <= `TOP_TEMP_RESET;
      top2_reg <= `TOP_TEMP_RESET;
      top3_reg <= `TOP_TEMP_RESET;
    end else if (!config_lock) begin
      if (wr_at(`ZONE1_TOP_TEMP_IDX)) top1_reg <= wbyte;
      if (wr_at(`ZONE2_TOP_TEMP_IDX)) top2_reg <= wbyte;
      if (wr_at(`ZONE3_TOP_TEMP_IDX)) top3_reg <= wbyte;
    end
  end

  // Step, delay and enable registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      step_reg   <= `ADJ_REG_RESET;
      amb_reg    <= `ADJ_REG_RESET;
      delay_reg  <= `ADJ_REG_RESET;
      enable_reg <= `ADJ_REG_RESET;
    end else if (!config_lock) begin
      if (wr_at(`REMOTE_STEP_IDX))        step_reg   <= wbyte & `STEP_FIELD_MASK;
      if (wr_at(`AMBIENT_STEP_DELAY_IDX)) amb_reg    <= wbyte & `AMB_FIELD_MASK;
      if (wr_at(`REMOTE_DELAY_IDX))       delay_reg  <= wbyte & `STEP_FIELD_MASK;
      if (wr_at(`ADJUST_ENABLE_IDX))      enable_reg <= wbyte & `ADJ_ENABLE_MASK;
    end
  end

  // Reserved writable register and interrupt mask
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rsvd_a_reg <= `RESERVED_A_RESET;
      mask_reg   <= `STATUS_RESET;
    end else begin
      if (wr_at(`RESERVED_CONFIG_A_IDX)) rsvd_a_reg <= wbyte;
      if (wr_at(`IRQ_MASK_IDX))          mask_reg   <= wbyte & `STATUS_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Zone instances, fixed sensor mapping
  // ----------------------------------------------------------------
  auto_low_limit_adjust_pkg::zone_cfg_s cfg1, cfg2, cfg3;
  assign cfg1 = '{adjust_on: enable_reg[`EN_Z1_BIT],
                  step_code: step_reg[`Z1_FIELD_LSB +: 2],
                  delay_code: delay_reg[`Z1_FIELD_LSB +: 2],
                  top_temp: top1_reg};
  assign cfg2 = '{adjust_on: enable_reg[`EN_Z2_BIT],
                  step_code: amb_reg[`Z2_STEP_LSB +: 2],
                  delay_code: amb_reg[`Z2_DELAY_LSB +: 2],
                  top_temp: top2_reg};
  assign cfg3 = '{adjust_on: enable_reg[`EN_Z3_BIT],
                  step_code: step_reg[`Z3_FIELD_LSB +: 2],
                  delay_code: delay_reg[`Z3_FIELD_LSB +: 2],
                  top_temp: top3_reg};

  zone_adjuster #(.MINUTE_CYCLES(MINUTE_CYCLES)) u_zone1 (
    .clk       (clk),
    .rst_n     (rst_n),
    .pg_rise   (pg_rise),
    .cfg       (cfg1),
    .reading   (zone1_reading),
    .sw_wr     (wr_at(`LOW_LIMIT_Z1_IDX)),
    .sw_data   (wbyte),
    .exceeded  (exceeded[0]),
    .low_limit (low1)
  );
  zone_adjuster #(.MINUTE_CYCLES(MINUTE_CYCLES)) u_zone2 (
    .clk       (clk),
    .rst_n     (rst_n),
    .pg_rise   (pg_rise),
    .cfg       (cfg2),
    .reading   (zone2_reading),
    .sw_wr     (wr_at(`LOW_LIMIT_Z2_IDX)),
    .sw_data   (wbyte),
    .exceeded  (exceeded[1]),
    .low_limit (low2)
  );
  zone_adjuster #(.MINUTE_CYCLES(MINUTE_CYCLES)) u_zone3 (
    .clk       (clk),
    .rst_n     (rst_n),
    .pg_rise   (pg_rise),
    .cfg       (cfg3),
    .reading   (zone3_reading),
    .sw_wr     (wr_at(`LOW_LIMIT_Z3_IDX)),
    .sw_data   (wbyte),
    .exceeded  (exceeded[2]),
    .low_limit (low3)
  );

  // ----------------------------------------------------------------
  // Top-exceeded status
  // ----------------------------------------------------------------
  // Exceed vector in status bit order
  assign exc_status = {exceeded[2], exceeded[0], exceeded[1]};

  // Set wins; write-one clears only an inactive zone
  always_ff @(posedge clk) begin
    if (!rst_n || pg_rise) begin
      status_reg <= `STATUS_RESET;
    end else if (wr_at(`TOP_STATUS_IDX)) begin
      status_reg <= {5'b0_0000, (status_reg[2:0] & ~(wbyte[2:0] & ~exc_status))
                    | exc_status};
    end else begin
      status_reg <= {5'b0_0000, status_reg[2:0] | exc_status};
    end
  end

  // Sticky event bits, cleared by read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      event_reg <= `STATUS_RESET;
    end else if (rd_en && hit && idx == `CONTROL_IDX) begin
      event_reg <= {5'b0_0000, exc_status & ~status_reg[2:0]};
    end else begin
      event_reg <= event_reg | {5'b0_0000, exc_status & ~status_reg[2:0]};
    end
  end

  // Interrupt outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      top_irq           <= 1'b0;
      monitor_irq_pin_n <= 1'b1;
    end else begin
      top_irq           <= (|status_reg[2:0]) & enable_reg[`TOP_INT_EN_BIT]
                           | (|(event_reg & mask_reg));
      monitor_irq_pin_n <= ~(((|status_reg[2:0]) & enable_reg[`TOP_INT_EN_BIT]
                           | (|(event_reg & mask_reg))) & global_int_en);
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    unique case (idx)
      `ZONE1_TOP_TEMP_IDX:      rdata = top1_reg;
      `ZONE3_TOP_TEMP_IDX:      rdata = top3_reg;
      `ZONE2_TOP_TEMP_IDX:      rdata = top2_reg;
      `REMOTE_STEP_IDX:         rdata = step_reg;
      `AMBIENT_STEP_DELAY_IDX:  rdata = amb_reg;
      `REMOTE_DELAY_IDX:        rdata = delay_reg;
      `ADJUST_ENABLE_IDX:       rdata = enable_reg;
      `TOP_STATUS_IDX:          rdata = status_reg;
      `RESERVED_CONFIG_A_IDX:   rdata = rsvd_a_reg;
      `RESERVED_READONLY_B_IDX: rdata = `RESERVED_B_RESET;
      `LOW_LIMIT_Z1_IDX:        rdata = low1;
      `LOW_LIMIT_Z2_IDX:        rdata = low2;
      `LOW_LIMIT_Z3_IDX:        rdata = low3;
      `CONTROL_IDX:             rdata = event_reg;
      `IRQ_MASK_IDX:            rdata = mask_reg;
      default:                  rdata = 8'h00;
    endcase
  end

  // Read data register, updated in the setup phase of a read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h00_0000, hit ? rdata : 8'h00};
    end
  end

endmodule : auto_low_limit_adjust
`default_nettype wire

// ### verif/auto_low_limit_adjust_chk.sv
// Port checker for the automatic low-limit adjust block
`timescale 1ns/100ps
`default_nettype none
`include "auto_low_limit_adjust_params.svh"
module auto_low_limit_adjust_chk #(
  parameter longint unsigned MINUTE_CYCLES = 20
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        global_int_en,
  input wire logic        top_irq,
  input wire logic        monitor_irq_pin_n
);
  // ----------------------------------------
  // Address map
  // ----------------------------------------
  // Bits a read may return, zero off the map
  function automatic logic [7:0] rd_mask(input logic [11:0] a);
    if (a[11:10] != 2'b00 || a[1:0] != 2'b00)
      return 8'h00;
    case (a[9:2])
      `ZONE1_TOP_TEMP_IDX, `ZONE3_TOP_TEMP_IDX, `ZONE2_TOP_TEMP_IDX: return 8'hff;
      `RESERVED_CONFIG_A_IDX, `CONTROL_IDX, `IRQ_MASK_IDX: return 8'hff;
      `LOW_LIMIT_Z1_IDX, `LOW_LIMIT_Z2_IDX, `LOW_LIMIT_Z3_IDX: return 8'hff;
      `REMOTE_STEP_IDX, `REMOTE_DELAY_IDX: return `STEP_FIELD_MASK;
      `AMBIENT_STEP_DELAY_IDX: return `AMB_FIELD_MASK;
      `ADJUST_ENABLE_IDX: return `ADJ_ENABLE_MASK;
      `TOP_STATUS_IDX: return `STATUS_MASK;
      default: return 8'h00;
    endcase
  endfunction : rd_mask
  // The read-only word reads zero yet is mapped
  function automatic logic mapped(input logic [11:0] a);
    return rd_mask(a) != 8'h00 || a == {2'b00, `RESERVED_READONLY_B_IDX, 2'b00};
  endfunction : mapped
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  err_by_map_a: assert property (psel && penable |-> pslverr == !mapped(paddr))
    else $error("Error response disagrees with the address map");
  idle_no_err_a: assert property (!psel |-> !pslverr)
    else $error("Error response without a transfer");
  rsvd_bits_zero_a: assert property (psel && penable && !pwrite |->
    (prdata[7:0] & ~rd_mask(paddr)) == 8'h00)
    else $error("Reserved bit read back as one");
  upper_bits_zero_a: assert property (psel && penable |-> prdata[31:8] == 24'h00_0000)
    else $error("Upper read data bits not zero");
  read_data_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("Read data changed without a setup phase");
  pin_needs_irq_a: assert property (!monitor_irq_pin_n |-> top_irq && $past(global_int_en))
    else $error("Interrupt pin active without a gated request");
  pin_follows_irq_a: assert property (top_irq && $past(global_int_en) |-> !monitor_irq_pin_n)
    else $error("Interrupt pin idle despite a gated request");
  pin_gated_a: assert property (!global_int_en |=> monitor_irq_pin_n)
    else $error("Interrupt pin active with the global enable off");
endmodule : auto_low_limit_adjust_chk
bind auto_low_limit_adjust auto_low_limit_adjust_chk #(.MINUTE_CYCLES(MINUTE_CYCLES)) chk_i (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .global_int_en(global_int_en),
  .top_irq(top_irq), .monitor_irq_pin_n(monitor_irq_pin_n));
`default_nettype wire

// ### verif/tb_auto_low_limit_adjust.sv
// Self-checking bench for the automatic low-limit adjust block
`timescale 1ns/100ps
`default_nettype none
`include "auto_low_limit_adjust_params.svh"
module tb_auto_low_limit_adjust;
  localparam int unsigned MINUTE = 40;
  localparam logic [7:0] IDX [10] = '{`ZONE1_TOP_TEMP_IDX, `ZONE3_TOP_TEMP_IDX,
    `ZONE2_TOP_TEMP_IDX, `REMOTE_STEP_IDX, `AMBIENT_STEP_DELAY_IDX, `REMOTE_DELAY_IDX,
    `ADJUST_ENABLE_IDX, `TOP_STATUS_IDX, `RESERVED_CONFIG_A_IDX, `RESERVED_READONLY_B_IDX};
  localparam logic [7:0] RST [10] = '{8'h2d, 8'h2d, 8'h2d, 0, 0, 0, 0, 0, 8'h03, 0};
  localparam logic [7:0] ONES [10] = '{8'hff, 8'hff, 8'hff, 8'hf0, 8'h33, 8'hf0, 8'h0f,
    8'h07, 8'h03, 8'h00};
  logic                             clk, rst_n, psel, penable, pwrite, last_err;
  logic                             main_power_good, config_lock, global_int_en;
  logic                             pready, pslverr, top_irq, monitor_irq_pin_n;
  logic [11:0]                      paddr;
  logic [31:0]                      pwdata, prdata;
  auto_low_limit_adjust_pkg::temp_t rd1, rd2, rd3;
  int                               bad_count, compares, cyc;

  auto_low_limit_adjust #(.MINUTE_CYCLES(MINUTE)) DUT (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .zone1_reading(rd1), .zone2_reading(rd2), .zone3_reading(rd3),
    .main_power_good(main_power_good), .config_lock(config_lock),
    .global_int_en(global_int_en), .top_irq(top_irq), .monitor_irq_pin_n(monitor_irq_pin_n));

  // Clock and cycle count
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One APB transfer, held until pready is sampled
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [7:0] q);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h00_0000, wd};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q        = prdata[7:0];
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    apb(1'b1, idx, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    apb(1'b0, idx, 8'h00, q);
    check(q, exp);
  endtask : rd
  task automatic wait_to(input int n);
    while (cyc < n) @(posedge clk);
  endtask : wait_to
  // Signed step down, stopping at the lowest value
  function automatic logic [7:0] dec(input logic [7:0] v, input int n);
    int t;
    t = int'($signed(v)) - n;
    return (t < -128) ? 8'h80 : t[7:0];
  endfunction : dec
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    final_report();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    {rst_n, psel, penable, pwrite, config_lock, paddr, pwdata} = '0;
    {main_power_good, global_int_en} = 2'b11;
    {rd1, rd2, rd3} = 24'h10_1010;
    {bad_count, compares, cyc} = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    for (int i = 0; i < 10; i++)
      rd(IDX[i], RST[i]);
    for (int i = 0; i < 10; i++)
      if (i < 8)
        wr(IDX[i], 8'hff);
    for (int i = 0; i < 10; i++)
      rd(IDX[i], ONES[i]);
    config_lock <= 1'b1;
    wr(`ZONE1_TOP_TEMP_IDX, 8'h11);
    wr(`ADJUST_ENABLE_IDX, 8'h00);
    rd(`ZONE1_TOP_TEMP_IDX, 8'hff);
    rd(`ADJUST_ENABLE_IDX, 8'h0f);
    config_lock <= 1'b0;
    rd(8'h10, 8'h00);
    check({7'h0, last_err}, 8'h01);
    // Every step and delay code, a different step code in each zone
    for (int c = 0; c < 4; c++) begin
      logic [1:0] k1, k2, k3;
      logic [7:0] lo1;
      int         t0;
      k1 = c;
      k3 = c + 1;
      k2 = c + 2;
      lo1 = (c == 3) ? 8'h81 : 8'h30;
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (8) @(posedge clk);
      wr(`REMOTE_STEP_IDX, {k1, k3, 4'h0});
      wr(`AMBIENT_STEP_DELAY_IDX, {2'b00, k2, 2'b00, k1});
      wr(`REMOTE_DELAY_IDX, {k1, k1, 4'h0});
      wr(`ZONE1_TOP_TEMP_IDX, 8'h20);
      wr(`ZONE3_TOP_TEMP_IDX, 8'h20);
      wr(`ZONE2_TOP_TEMP_IDX, 8'h20);
      wr(`LOW_LIMIT_Z1_IDX, lo1);
      wr(`LOW_LIMIT_Z2_IDX, 8'h30);
      wr(`LOW_LIMIT_Z3_IDX, 8'h30);
      wr(`IRQ_MASK_IDX, (c == 2) ? 8'h07 : 8'h00);
      wr(`ADJUST_ENABLE_IDX, {4'h0, 2'b11, c != 3, c == 0 || c == 3});
      global_int_en <= (c != 3);
      {rd1, rd2, rd3} <= 24'h28_2828;
      t0 = cyc;
      wait_to(t0 + 8);
      rd(`LOW_LIMIT_Z1_IDX, dec(lo1, 2 * k1 + 2));
      rd(`LOW_LIMIT_Z3_IDX, dec(8'h30, 2 * k3 + 2));
      rd(`LOW_LIMIT_Z2_IDX, (c == 3) ? 8'h30 : dec(8'h30, 2 * k2 + 2));
      rd(`TOP_STATUS_IDX, 8'h07);
      check({7'h0, top_irq}, {7'h0, c != 1});
      check({7'h0, monitor_irq_pin_n}, {7'h0, c == 1 || c == 3});
      wait_to(t0 + MINUTE * (c + 1) - 10);
      rd(`LOW_LIMIT_Z1_IDX, dec(lo1, 2 * k1 + 2));
      wait_to(t0 + MINUTE * (c + 1) + 12);
      rd(`LOW_LIMIT_Z1_IDX, dec(dec(lo1, 2 * k1 + 2), 2 * k1 + 2));
      wr(`TOP_STATUS_IDX, 8'h07);
      rd(`TOP_STATUS_IDX, 8'h07);
      {rd1, rd2, rd3} <= 24'h10_1010;
      rd(`CONTROL_IDX, 8'h07);
      rd(`CONTROL_IDX, 8'h00);
      if (c[0]) begin
        wr(`TOP_STATUS_IDX, 8'h07);
        rd(`TOP_STATUS_IDX, 8'h00);
      end else begin
        main_power_good <= 1'b0;
        repeat (6) @(posedge clk);
        main_power_good <= 1'b1;
        repeat (8) @(posedge clk);
        rd(`ZONE1_TOP_TEMP_IDX, 8'h2d);
        rd(`TOP_STATUS_IDX, 8'h00);
      end
      repeat (3) @(posedge clk);
      check({7'h0, top_irq}, 8'h00);
    end
    final_report();
  end
endmodule : tb_auto_low_limit_adjust
`default_nettype wire
